// *** src/macrocell_pkg.sv ***
/*
  Shared constants and types for one configurable logic-cell slice:
  clock choice, control-term counts, output-buffer modes and reset values.
  Assumes a single 200 MHz system clock samples every pin-level input.
*/
package macrocell_pkg;

  // clock sources and control terms
  localparam int NUM_CLOCKS = 4;
  localparam int NUM_TERMS = 6;
  localparam int NUM_OE_TERMS = 4;
  localparam int TERM_SET = 0;
  localparam int TERM_CLEAR = 1;
  localparam int TERM_OE_BASE = 2;

  // pin sampling: three stages, change accepted when second and third agree
  localparam int SYNC_STAGES = 3;
  localparam int NUM_PIN_INPUTS = 6;
  localparam int PIN_SYNC_ZERO = 0;
  localparam int PIN_FLEX_ONE = 1;
  localparam int PIN_FLEX_TWO = 2;
  localparam int PIN_FLEX_THREE = 3;
  localparam int PIN_FLOAT = 4;
  localparam int PIN_IO = 5;

  // width of the routing-array bus into the control terms
  localparam int ROUTE_WIDTH_DEFAULT = 36;

  // values after reset
  localparam logic STATE_RESET = 1'b0;
  localparam logic [SYNC_STAGES-1:0] SYNC_RESET = 3'h0;
  localparam logic FLOAT_N_RESET = 1'b1;
  localparam logic [NUM_CLOCKS-1:0] LEVEL_RESET = 4'h0;

  typedef enum logic [1:0] {
    OE_BY_TERM,
    OE_ALWAYS_ON,
    OE_ALWAYS_OFF
  } oe_mode_t;

  typedef enum logic [1:0] {
    CLK_SYNC_ZERO,
    CLK_FLEX_ONE,
    CLK_FLEX_TWO,
    CLK_FLEX_THREE
  } clk_sel_t;

endpackage : macrocell_pkg

// *** src/control_term.sv ***
/*
  One control term: a masked sum term or product term over the routing
  array. Assumes its inputs are already on the system clock.
*/
`timescale 1ns/1ps
module control_term #(
  parameter int WIDTH = 36
) (
  input wire logic [WIDTH-1:0] route_in, // routing-array signals
  input wire logic [WIDTH-1:0] use_mask, // 1 = input takes part in the term
  input wire logic sum_mode, // 1 = sum term, 0 = product term
  output logic term_out // term value
);

  wire logic any_hit;
  wire logic all_hit;
  wire logic none_used;

  assign any_hit = |(route_in & use_mask);
  assign all_hit = &(route_in | ~use_mask);
  // an empty term reads low either way, so an unprogrammed term stays idle
  assign none_used = ~|use_mask;
  assign term_out = none_used ? 1'b0 : (sum_mode ? any_hit : all_hit);

endmodule : control_term

// *** src/macrocell_slice.sv ***
/*
  One logic-cell slice: D/T flip-flop with a choice of four clocks and edge,
  control-term preset/clear and output enable, global float pin, and the two
  feedback paths into the routing array.
  Assumes one system clock fast enough to sample every clock pin; clock pins
  are sampled, not used as clocks, and equation clocks are on clk already.
*/
// Behaviour
// - flip-flop works as D type or T type by configuration.
// - flip-flop captures on rising or falling edge of its chosen clock.
// - four clock sources exist and any one can be selected.
// - clocks one to three take an outside pin or an internal equation.
// - control terms a and b drive preset and clear of the flip-flop.
// - preset/clear can be disabled; then both terms are ignored.
// - reset leaves the flip-flop holding zero.
// - any of the four remaining terms can enable the output buffer.
// - output buffer can instead be always enabled or always disabled.
// - global float pin low floats the output regardless of configuration.
// - feedback before the buffer from the cell, after it from the pin.
// - driving a pin enables the buffer and feeds cell logic back.
// - input pin floats the buffer; pin and buried cell both feed back.
// - each of six control terms is a sum or product term.
// - preset and clear act at once, without waiting for a clock edge.
`timescale 1ns/1ps
module macrocell_slice
  import macrocell_pkg::*;
#(
  parameter int ROUTE_WIDTH = macrocell_pkg::ROUTE_WIDTH_DEFAULT
) (
  input wire logic clk, // system clock, 200 MHz
  input wire logic resetn, // asynchronous reset, active low
  input wire logic [ROUTE_WIDTH-1:0] routing_array, // routing-array signals
  input wire logic [macrocell_pkg::NUM_TERMS*ROUTE_WIDTH-1:0] term_mask, // per-term input mask
  input wire logic [macrocell_pkg::NUM_TERMS-1:0] term_sum_mode, // 1 = sum term
  input wire logic sync_clock_zero, // outside clock pin zero
  input wire logic flex_clock_one, // outside clock pin one
  input wire logic flex_clock_two, // outside clock pin two
  input wire logic flex_clock_three, // outside clock pin three
  input wire logic [2:0] flex_from_equation, // 1 = flex clock from equation
  input wire logic [2:0] flex_equation, // equation clocks, on clk
  input wire macrocell_pkg::clk_sel_t clock_select, // which clock source
  input wire logic falling_edge, // 1 = capture on falling edge
  input wire logic toggle_mode, // 1 = T type, 0 = D type
  input wire logic cell_input, // D or T input from the logic arrays
  input wire logic set_clear_enable, // 1 = control terms a/b act
  input wire macrocell_pkg::oe_mode_t oe_mode, // enable source of buffer
  input wire logic [1:0] oe_term_select, // which of the four enable terms
  input wire logic global_float_n, // float pin, low floats all outputs
  input wire logic pin_in, // level seen on the I/O pin
  output logic pin_out, // value driven onto the I/O pin
  output logic pin_oe, // 1 = buffer drives the pin
  output logic cell_feedback, // cell path into the routing array
  output logic pin_feedback, // pin path into the routing array
  output logic cell_state // stored flip-flop bit
);
  import macrocell_pkg::*;

  // three-stage samplers with agreement filter for every pin input
  wire logic [NUM_PIN_INPUTS-1:0] pins_raw;
  logic [SYNC_STAGES-1:0] sync_reg [NUM_PIN_INPUTS];
  logic [NUM_PIN_INPUTS-1:0] filt_reg;

  assign pins_raw = {pin_in, global_float_n, flex_clock_three, flex_clock_two,
                     flex_clock_one, sync_clock_zero};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PIN_INPUTS; gi++) begin : g_pin_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync_reg[gi] <= SYNC_RESET;
        end else begin
          sync_reg[gi] <= {sync_reg[gi][SYNC_STAGES-2:0], pins_raw[gi]};
        end
      end
      // stage one is read only by stage two; filter looks at two and three
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          filt_reg[gi] <= (gi == PIN_FLOAT) ? FLOAT_N_RESET : STATE_RESET;
        end else if (sync_reg[gi][1] == sync_reg[gi][2]) begin
          filt_reg[gi] <= sync_reg[gi][1];
        end
      end
    end
  endgenerate

  // control terms
  logic [NUM_TERMS-1:0] term_val;

  generate
    for (gi = 0; gi < NUM_TERMS; gi++) begin : g_term
      control_term #(
        .WIDTH(ROUTE_WIDTH)
      ) u_term (
        .route_in(routing_array),
        .use_mask(term_mask[gi*ROUTE_WIDTH +: ROUTE_WIDTH]),
        .sum_mode(term_sum_mode[gi]),
        .term_out(term_val[gi])
      );
    end
  endgenerate

  // clock source levels
  wire logic [NUM_CLOCKS-1:0] clock_level;
  wire logic sel_level;
  logic prev_level_reg;
  wire logic active_edge;

  // clock zero has no equation option: only its pin is ever used
  assign clock_level[0] = filt_reg[PIN_SYNC_ZERO];
  generate
    for (gi = 1; gi < NUM_CLOCKS; gi++) begin : g_flex
      // equation clocks already live on clk and skip the samplers
      assign clock_level[gi] = flex_from_equation[gi-1] ? flex_equation[gi-1]
                                                         : filt_reg[gi];
    end
  endgenerate

  assign sel_level = clock_level[clock_select];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_level_reg <= STATE_RESET;
    end else begin
      prev_level_reg <= sel_level;
    end
  end

  // switching source or edge may see one stray edge; reconfigure when idle
  assign active_edge = falling_edge ? (prev_level_reg & ~sel_level)
                                    : (~prev_level_reg & sel_level);

  // preset / clear
  wire logic do_set;
  wire logic do_clear;

  assign do_set = set_clear_enable & term_val[TERM_SET];
  assign do_clear = set_clear_enable & term_val[TERM_CLEAR];

  // storage element
  logic state_reg;
  logic state_next;
  wire logic captured;

  assign captured = toggle_mode ? (state_reg ^ cell_input) : cell_input;

  // clear wins when both terms are active, so a conflict settles low
  always_comb begin
    if (do_clear) begin
      state_next = 1'b0;
    end else if (do_set) begin
      state_next = 1'b1;
    end else if (active_edge) begin
      state_next = captured;
    end else begin
      state_next = state_reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // preset/clear reach the outputs in the same cycle, not at an edge
  wire logic cell_value;
  assign cell_value = do_clear ? 1'b0 : (do_set ? 1'b1 : state_reg);

  // output buffer enable
  wire logic term_enable;
  wire logic buffer_enable;
  wire logic float_n_level;

  assign term_enable = term_val[TERM_OE_BASE + int'(oe_term_select)];
  assign float_n_level = filt_reg[PIN_FLOAT];
  assign buffer_enable = (oe_mode == OE_ALWAYS_ON) ? 1'b1 :
                         (oe_mode == OE_BY_TERM) ? term_enable : 1'b0;

  assign pin_oe = buffer_enable & float_n_level;
  assign pin_out = cell_value;
  assign cell_feedback = cell_value;
  // pin path always follows the pin, driven or not
  assign pin_feedback = filt_reg[PIN_IO];
  assign cell_state = state_reg;

  // checks
  d_capture_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (active_edge && !toggle_mode && !do_set && !do_clear)
      |=> (state_reg == $past(cell_input)))
    else $error("d type did not capture its input");

  t_toggle_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (active_edge && toggle_mode && cell_input && !do_set && !do_clear)
      |=> (state_reg != $past(state_reg)))
    else $error("t type did not invert on active edge");

  t_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (toggle_mode && !cell_input && !do_set && !do_clear) |=> $stable(state_reg))
    else $error("t type changed with input low");

  edge_only_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (!active_edge && !do_set && !do_clear) |=> $stable(state_reg))
    else $error("flip-flop changed without active edge");

  edge_polarity_a: assert property (
    @(posedge clk) disable iff (!resetn)
    active_edge |-> (falling_edge ? $fell(sel_level) : $rose(sel_level)))
    else $error("capture on the wrong clock edge");

  set_now_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (do_set && !do_clear) |-> (cell_feedback ##1 state_reg))
    else $error("preset not applied at once");

  clear_now_a: assert property (
    @(posedge clk) disable iff (!resetn)
    do_clear |-> (!cell_feedback ##1 !state_reg))
    else $error("clear not applied at once");

  sc_disabled_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (!set_clear_enable && !active_edge) |=> $stable(state_reg))
    else $error("disabled preset/clear still acted");

  float_all_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (sync_reg[PIN_FLOAT][2:1] == 2'h0) |=> !pin_oe)
    else $error("output driven while float pin low");

  always_on_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (oe_mode == OE_ALWAYS_ON && float_n_level) |-> pin_oe)
    else $error("always-on buffer not driving");

  always_off_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (oe_mode == OE_ALWAYS_OFF) |-> !pin_oe)
    else $error("always-off buffer driving");

  pin_path_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (sync_reg[PIN_IO][2:1] == 2'h3) |=> pin_feedback)
    else $error("pin path does not follow the pin");

  reset_zero_a: assert property (
    @(posedge clk)
    !resetn |-> (cell_state == STATE_RESET))
    else $error("flip-flop not zero during reset");

  clock_zero_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clock_select == CLK_SYNC_ZERO) |-> (sel_level == filt_reg[PIN_SYNC_ZERO]))
    else $error("clock zero not taken from its pin");

  eq_one_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clock_select == CLK_FLEX_ONE && flex_from_equation[0]) |-> (sel_level == flex_equation[0]))
    else $error("clock one not taken from its equation");

  eq_three_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clock_select == CLK_FLEX_THREE && flex_from_equation[2]) |-> (sel_level == flex_equation[2]))
    else $error("clock three not taken from its equation");

  pin_clock_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clock_select == CLK_FLEX_TWO && !flex_from_equation[1])
      |-> (sel_level == filt_reg[PIN_FLEX_TWO]))
    else $error("clock two not taken from its pin");

  oe_term_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (oe_mode == OE_BY_TERM && float_n_level)
      |-> (pin_oe == term_val[TERM_OE_BASE + int'(oe_term_select)]))
    else $error("buffer does not follow its enable term");

  oe_unused_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (oe_mode == oe_mode_t'(2'h3)) |-> !pin_oe)
    else $error("unused enable code drives the pin");

  float_on_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (sync_reg[PIN_FLOAT][2:1] == 2'h3) ##1 (oe_mode == OE_ALWAYS_ON) |-> pin_oe)
    else $error("buffer stays floated after float pin high");

  cell_path_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (!do_set && !do_clear) |-> (cell_feedback == state_reg))
    else $error("cell path does not show the stored bit");

  out_match_a: assert property (
    @(posedge clk) disable iff (!resetn)
    pin_oe |-> (pin_out == cell_feedback))
    else $error("driven pin differs from cell path");

  pin_low_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (sync_reg[PIN_IO][2:1] == 2'h0) |=> !pin_feedback)
    else $error("pin path does not follow a low pin");

  glitch_block_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (sync_reg[PIN_IO][2] != sync_reg[PIN_IO][1]) |=> $stable(pin_feedback))
    else $error("pin path moved while samplers disagree");

endmodule : macrocell_slice

// *** verification/board_side.sv ***
/*
  Board side of one cell slice: clock pin drivers and
  the I/O pin wire with a tie-off.
  Assumes the bench steers wanted levels at the falling clock edge.
*/
`timescale 1ns/1ps
module board_side (
  input wire logic [3:0] clk_req, // wanted clock pin levels
  input wire logic drive_en, // board drives the pin
  input wire logic drive_val, // board value for the pin
  input wire logic pin_out, // cell value for the pin
  input wire logic pin_oe, // cell drives the pin
  output logic [3:0] clk_pins, // outside clock pins
  output logic pin_level // resolved pin level
);
  assign clk_pins = clk_req;
  // an undriven pin is pulled high, never left floating
  assign pin_level = pin_oe ? pin_out : (drive_en ? drive_val : 1'b1);
endmodule : board_side

// *** verification/test_programmable_macrocell.sv ***
/*
  Self-checking bench for one cell slice, random with fixed seed.
  Assumes macrocell_pkg and the board model are compiled first.
*/
`timescale 1ns/1ps
module test_programmable_macrocell;
  import macrocell_pkg::*;
  localparam int W = ROUTE_WIDTH_DEFAULT;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [W-1:0] route = '0;
  logic [NUM_TERMS*W-1:0] mask = '0;
  logic [NUM_TERMS-1:0] sum_mode = '0;
  logic [3:0] clk_req = '0;
  logic [3:0] clk_pins;
  logic [2:0] from_eq = '0;
  logic [2:0] eq_clk = '0;
  clk_sel_t sel = CLK_SYNC_ZERO;
  oe_mode_t oe = OE_ALWAYS_OFF;
  logic [1:0] oe_sel = '0;
  logic fall = 0, tog = 0, din = 0, sc_en = 0, float_n = 1, drv_en = 0, drv_val = 0;
  logic pin_level, pin_out, pin_oe, cell_fb, pin_fb, state, exp_state, old;
  int errors = 0, checks_done = 0, cycles = 0;

  always #2.5 clk = ~clk;

  macrocell_slice dut (.clk(clk), .resetn(resetn), .routing_array(route),
    .term_mask(mask), .term_sum_mode(sum_mode), .sync_clock_zero(clk_pins[0]),
    .flex_clock_one(clk_pins[1]), .flex_clock_two(clk_pins[2]),
    .flex_clock_three(clk_pins[3]), .flex_from_equation(from_eq), .flex_equation(eq_clk),
    .clock_select(sel), .falling_edge(fall), .toggle_mode(tog), .cell_input(din),
    .set_clear_enable(sc_en), .oe_mode(oe), .oe_term_select(oe_sel),
    .global_float_n(float_n), .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .cell_feedback(cell_fb), .pin_feedback(pin_fb), .cell_state(state));

  board_side board (.clk_req(clk_req), .drive_en(drv_en), .drive_val(drv_val),
    .pin_out(pin_out), .pin_oe(pin_oe), .clk_pins(clk_pins), .pin_level(pin_level));

  // each term sees two route bits, so sum and product differ
  function automatic logic term(input int k);
    return sum_mode[k] ? (route[k] | route[k+6]) : (route[k] & route[k+6]);
  endfunction : term

  function automatic logic cell_val();
    if (sc_en && term(TERM_CLEAR)) return 1'b0;
    if (sc_en && term(TERM_SET)) return 1'b1;
    return exp_state;
  endfunction : cell_val

  function automatic logic oe_val();
    if (oe == OE_ALWAYS_ON) return float_n;
    if (oe == OE_BY_TERM) return float_n & term(TERM_OE_BASE + int'(oe_sel));
    return 1'b0;
  endfunction : oe_val

  task automatic cmp(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp

  task automatic final_report();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // a sampled pin change reaches the flip-flop on the 5th edge; 6 leaves margin
  task automatic flip(input int src);
    @(negedge clk);
    if (src > 0 && from_eq[src-1]) eq_clk[src-1] = ~eq_clk[src-1];
    else clk_req[src] = ~clk_req[src];
    repeat (6) @(negedge clk);
  endtask : flip

  task automatic settle();
    repeat (10) @(negedge clk);
  endtask : settle

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'h9657));
    for (int k = 0; k < NUM_TERMS; k++) mask[k*W +: W] = (W'(1) << k) | (W'(1) << (k + 6));
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    exp_state = 1'b0;
    cmp(state, 1'b0);
    for (int s = 0; s < NUM_CLOCKS; s++) begin
      for (int m = 0; m < 8; m++) begin
        @(negedge clk);
        sel = clk_sel_t'(s);
        from_eq = m[2] ? 3'h7 : 3'h0;
        fall = m[1];
        tog = m[0];
        din = 1'($urandom);
        old = exp_state;
        exp_state = tog ? old ^ din : din;
        flip(s);
        cmp(state, fall ? old : exp_state);
        flip(s);
        cmp(state, exp_state);
        cmp(cell_fb, exp_state);
      end
    end
    repeat (200) begin
      @(negedge clk);
      cmp(state, exp_state);
      route = W'({$urandom, $urandom});
      sum_mode = NUM_TERMS'($urandom);
      sc_en = 1'($urandom);
      oe = oe_mode_t'($urandom);
      oe_sel = 2'($urandom);
      #1;
      cmp(cell_fb, cell_val());
      cmp(pin_out, cell_val());
      cmp(pin_oe, oe_val());
      exp_state = cell_val();
    end
    @(negedge clk);
    sc_en = 1'b0;
    oe = OE_ALWAYS_ON;
    float_n = 1'b0;
    settle();
    cmp(pin_oe, 1'b0);
    float_n = 1'b1;
    settle();
    cmp(pin_oe, 1'b1);
    cmp(pin_fb, exp_state);
    oe = OE_ALWAYS_OFF;
    drv_en = 1'b1;
    drv_val = ~exp_state;
    settle();
    cmp(pin_oe, 1'b0);
    cmp(pin_fb, ~exp_state);
    cmp(cell_fb, exp_state);
    resetn = 1'b0;
    #1;
    cmp(state, 1'b0);
    final_report();
  end
endmodule : test_programmable_macrocell
